/* rtl/spwm_pkg.sv */
// Functional notes
// - 8-bit period count compared to limit; cleared on increment after equality.
// - period lasts (limit+1) x 4 clocks x prescale ratio.
// - pin set at each rollover unless duty value is zero.
// - rollover copies buffered duty into active latch and low-bit latch.
// - duty is 10 bits: buffer holds upper 8, control bits 5-4 lower 2.
// - duty writes accepted anytime, take effect only at next rollover.
// - in pwm mode the active duty latch is read only.
// - time base is count plus clock counter or two prescaler bits.
// - time base equal to latched duty drives pin low.
// - postscale select has no effect on period or frequency.
// - duty beyond period never matches; pin keeps its level.
// - resolution is log2 of 4 x (limit+1); 10 bits at 255.
// - sleep freezes count and pin; counting resumes from held value.
// - reset restores register defaults and releases the pin.
// - compare codes 1011 trigger, 1010 flag, 1001 clear, 1000 set, 0010 toggle.
// - capture codes 0111 16th, 0110 4th, 0101 rising, 0100 falling edge.
// - code 0000 turns module off and resets it; 0011, 0001 reserved. Here 0000 only clears the pin latch.
// - codes 11xx select pwm; bits 5-4 used only there.
// - control bits 7-6 read as zero.
package spwm_pkg;
    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_DBUF = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_DACT = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_TCON = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 3'h5;
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DLOW_LSB = 4;
    localparam int TCON_PS_LSB = 0;
    localparam int TCON_RUN_BIT = 2;
    localparam int TCON_POST_LSB = 3;
    // --------------------------------------------------------------
    // mode codes
    // --------------------------------------------------------------
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_RSV1 = 4'h1;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_RSV3 = 4'h3;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_FLAG = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
    localparam logic [1:0] MODE_PWM_HI = 2'h3;
    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV4 = 2'h1;
    localparam logic [1:0] OSC_LAST = 2'h3;
    localparam logic [3:0] PS_LAST = 4'hF;
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] dlow;
        logic [7:0] dbuf;
        logic [7:0] dact;
        logic [1:0] dlow_latch;
        logic [7:0] limit;
        logic [6:0] tcon;
        logic [7:0] count;
        logic [1:0] osc_cnt;
        logic [3:0] ps_cnt;
        logic pin;
        logic [7:0] rdata;
    } spwm_state_t;
    localparam spwm_state_t STATE_RST = '0;
endpackage : spwm_pkg

/* rtl/spwm_top.sv */
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module spwm_top
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [spwm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // power state
    input wire logic sleep_req,
    // waveform pin
    output logic waveform_pin_o,
    output logic waveform_pin_oe
);
    import spwm_pkg::*;

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    spwm_state_t st_reg;
    spwm_state_t st_next;
    logic pwm_on;
    logic run;
    logic osc_end;
    logic ps_end;
    logic tick;
    logic wrap;
    logic [1:0] prescale;
    logic [1:0] tb_low;
    logic [9:0] time_base;
    logic [9:0] duty_active;
    logic [9:0] duty_buffered;
    logic [9:0] tb_ahead;
    logic cmp_mode;
    logic cap_mode;
    logic rsv_mode;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.rdata = 8'h00;
        pwm_on = (st_reg.mode[3:2] == MODE_PWM_HI);
        prescale = st_reg.tcon[TCON_PS_LSB +: 2];
        run = st_reg.tcon[TCON_RUN_BIT] && !sleep_req;
        osc_end = (st_reg.osc_cnt == OSC_LAST);
        // postscale field is stored only, never consulted
        case (prescale)
            PS_DIV1:
            begin
                ps_end = 1'b1;
                tb_low = st_reg.osc_cnt;
            end
            PS_DIV4:
            begin
                ps_end = (st_reg.ps_cnt[1:0] == OSC_LAST);
                tb_low = st_reg.ps_cnt[1:0];
            end
            default:
            begin
                ps_end = (st_reg.ps_cnt == PS_LAST);
                tb_low = st_reg.ps_cnt[3:2];
            end
        endcase
        tick = run && osc_end && ps_end;
        wrap = tick && (st_reg.count == st_reg.limit);
        time_base = {st_reg.count, tb_low};
        duty_active = {st_reg.dact, st_reg.dlow_latch};
        duty_buffered = {st_reg.dbuf, st_reg.dlow};
        // engine modes only stop the pwm path here
        cmp_mode = (st_reg.mode == MODE_CMP_SET)
            || (st_reg.mode == MODE_CMP_CLEAR)
            || (st_reg.mode == MODE_CMP_FLAG)
            || (st_reg.mode == MODE_CMP_TRIG)
            || (st_reg.mode == MODE_CMP_TOGGLE);
        cap_mode = (st_reg.mode == MODE_CAP_FALL)
            || (st_reg.mode == MODE_CAP_RISE)
            || (st_reg.mode == MODE_CAP_RISE4)
            || (st_reg.mode == MODE_CAP_RISE16);
        rsv_mode = (st_reg.mode == MODE_RSV1)
            || (st_reg.mode == MODE_RSV3);
        // prescaler chain
        if (run)
        begin
            st_next.osc_cnt = 2'(st_reg.osc_cnt + 2'h1);
            if (osc_end)
            begin
                if (ps_end)
                begin
                    st_next.ps_cnt = 4'h0;
                end
                else
                begin
                    st_next.ps_cnt = 4'(st_reg.ps_cnt + 4'h1);
                end
            end
        end
        // period counter and rollover
        if (wrap)
        begin
            st_next.count = 8'h00;
            if (pwm_on)
            begin
                st_next.dact = st_reg.dbuf;
                st_next.dlow_latch = st_reg.dlow;
                st_next.pin = (duty_buffered != 10'h000);
            end
        end
        else if (tick)
        begin
            st_next.count = 8'(st_reg.count + 8'h01);
        end
        // time base one cycle ahead, so the pin falls on the match step
        case (prescale)
            PS_DIV1:
            begin
                tb_ahead = {st_next.count, st_next.osc_cnt};
            end
            PS_DIV4:
            begin
                tb_ahead = {st_next.count, st_next.ps_cnt[1:0]};
            end
            default:
            begin
                tb_ahead = {st_next.count, st_next.ps_cnt[3:2]};
            end
        endcase
        // duty match, never reached when duty exceeds the period
        if (!wrap && run && pwm_on && tb_ahead == duty_active)
        begin
            st_next.pin = 1'b0;
        end
        // off mode clears the output latch
        if (st_reg.mode == MODE_OFF)
        begin
            st_next.pin = 1'b0;
        end
        // register writes
        if (reg_wr)
        begin
            case (reg_addr)
                ADDR_CTRL:
                begin
                    st_next.mode = reg_wdata[CTRL_MODE_LSB +: 4];
                    st_next.dlow = reg_wdata[CTRL_DLOW_LSB +: 2];
                end
                ADDR_DBUF:
                begin
                    st_next.dbuf = reg_wdata;
                end
                ADDR_DACT:
                begin
                    if (!pwm_on)
                    begin
                        st_next.dact = reg_wdata;
                    end
                end
                ADDR_LIMIT:
                begin
                    st_next.limit = reg_wdata;
                end
                ADDR_TCON:
                begin
                    st_next.tcon = reg_wdata[6:0];
                end
                ADDR_COUNT:
                begin
                    st_next.count = reg_wdata;
                    st_next.osc_cnt = 2'h0;
                    st_next.ps_cnt = 4'h0;
                end
                default:
                begin
                    st_next.count = st_next.count;
                end
            endcase
        end
        // register reads, data in the following cycle
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_CTRL:
                begin
                    st_next.rdata = {2'h0, st_reg.dlow, st_reg.mode};
                end
                ADDR_DBUF:
                begin
                    st_next.rdata = st_reg.dbuf;
                end
                ADDR_DACT:
                begin
                    st_next.rdata = st_reg.dact;
                end
                ADDR_LIMIT:
                begin
                    st_next.rdata = st_reg.limit;
                end
                ADDR_TCON:
                begin
                    st_next.rdata = {1'b0, st_reg.tcon};
                end
                ADDR_COUNT:
                begin
                    st_next.rdata = st_reg.count;
                end
                default:
                begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg <= STATE_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign reg_rdata = st_reg.rdata;
    assign waveform_pin_o = st_reg.pin;
    assign waveform_pin_oe = pwm_on;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_wrap_pwm;
        wrap && pwm_on;
    endsequence

    sequence s_no_tick3;
        !tick [*3];
    endsequence

    sequence s_no_tick8;
        !tick [*8];
    endsequence

    sequence s_no_tick7;
        !tick [*7];
    endsequence

    a_wrap_clears_count: assert property (
        wrap && !reg_wr |=> st_reg.count == 8'h00)
        else $error("count not cleared at rollover");

    a_tick_spacing: assert property (
        disable iff (sys_rst || sleep_req || reg_wr)
        tick && prescale == PS_DIV1 |=> s_no_tick3 ##1 tick)
        else $error("count step not four clocks");

    a_pin_set_wrap: assert property (
        s_wrap_pwm ##0 duty_buffered != 10'h000 |=> st_reg.pin)
        else $error("pin not set at rollover");

    a_zero_duty_low: assert property (
        s_wrap_pwm ##0 duty_buffered == 10'h000 |=> !st_reg.pin)
        else $error("pin set with zero duty");

    a_latch_copy: assert property (
        s_wrap_pwm |=> duty_active == $past(duty_buffered))
        else $error("duty not latched at rollover");

    a_latch_holds: assert property (
        pwm_on && !wrap && !reg_wr |=> $stable(duty_active))
        else $error("active duty moved mid period");

    a_active_ro: assert property (
        pwm_on && !wrap && reg_wr && reg_addr == ADDR_DACT
        |=> $stable(st_reg.dact))
        else $error("active duty written in pwm mode");

    a_match_clear: assert property (
        pwm_on && run && !wrap && tb_ahead == duty_active
        |=> !st_reg.pin)
        else $error("pin not cleared on duty match");

    a_sleep_freeze: assert property (
        sleep_req && !reg_wr |=> $stable(st_reg.count)
        && $stable(st_reg.pin))
        else $error("state moved during sleep");

    a_off_clears: assert property (
        st_reg.mode == MODE_OFF |=> !st_reg.pin)
        else $error("pin latch not cleared when off");

    a_ctrl_top_zero: assert property (
        reg_rd && reg_addr == ADDR_CTRL |=> reg_rdata[7:6] == 2'h0)
        else $error("control bits 7-6 not zero");

    a_no_drive_off: assert property (
        !pwm_on |-> !waveform_pin_oe ##1 (pwm_on || !waveform_pin_oe))
        else $error("pin driven outside pwm mode");

    a_div4_spacing: assert property (
        disable iff (sys_rst || sleep_req || reg_wr)
        tick && prescale == PS_DIV4 |=> s_no_tick8 ##1 s_no_tick7 ##1 tick)
        else $error("count step not sixteen clocks");

    a_count_step: assert property (
        tick && !wrap && !reg_wr
        |=> st_reg.count == 8'($past(st_reg.count) + 8'h01))
        else $error("count did not advance on tick");

    a_dlow_latch: assert property (
        s_wrap_pwm
        |=> st_reg.dlow_latch == $past(st_reg.dlow))
        else $error("low duty bits not latched");

    a_buf_write: assert property (
        reg_wr && reg_addr == ADDR_DBUF
        |=> st_reg.dbuf == $past(reg_wdata))
        else $error("duty buffer write lost");

    a_pin_hold: assert property (
        pwm_on && !wrap && tb_ahead != duty_active
        |=> $stable(st_reg.pin))
        else $error("pin moved without match or rollover");

    a_sleep_oe: assert property (
        sleep_req && !reg_wr |=> $stable(waveform_pin_oe))
        else $error("pin enable moved during sleep");

    a_reset_idle: assert property (
        disable iff (1'b0)
        sys_rst |=> !waveform_pin_oe && !st_reg.pin && reg_rdata == 8'h00)
        else $error("state not idle after reset");

    a_cmp_no_latch: assert property (
        cmp_mode && !reg_wr
        |=> $stable(duty_active))
        else $error("duty latched in compare mode");

    a_cmp_pin_held: assert property (
        cmp_mode && !reg_wr |=> $stable(st_reg.pin))
        else $error("pin moved in compare mode");

    a_cap_no_latch: assert property (
        cap_mode && !reg_wr
        |=> $stable(duty_active))
        else $error("duty latched in capture mode");

    a_cap_no_drive: assert property (
        cap_mode |-> !waveform_pin_oe)
        else $error("pin driven in capture mode");

    a_rsv_no_drive: assert property (
        rsv_mode |-> !waveform_pin_oe)
        else $error("pin driven in reserved mode");

    a_off_no_latch: assert property (
        st_reg.mode == MODE_OFF && !reg_wr
        |=> $stable(duty_active))
        else $error("duty latched while off");

endmodule : spwm_top

/* verif/spwm_load.sv */
`timescale 1ns/1ns
module spwm_load
(
    // clock
    input wire logic clk,
    // pin side
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic line,
    // meter
    input wire logic clr,
    output logic [15:0] high_cnt
);
    typedef struct packed {
        logic [15:0] hi;
    } spwm_meter_t;
    spwm_meter_t st_reg;
    spwm_meter_t st_next;
    // ----------------------------------------------------------
    // load with pull-down, counts high cycles
    // ----------------------------------------------------------
    assign line = pin_oe ? pin_o : 1'b0;
    always_comb
    begin
        st_next = st_reg;
        st_next.hi = st_reg.hi + {15'h0000, line};
        if (clr)
        begin
            st_next = '0;
        end
    end
    always_ff @(posedge clk)
    begin
        st_reg <= st_next;
    end
    assign high_cnt = st_reg.hi;
endmodule : spwm_load

/* verif/spwm_top_test.sv */
`timescale 1ns/1ns
module spwm_top_test;
    import spwm_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sleep_req = 1'b0;
    logic pin_o;
    logic pin_oe;
    logic line;
    logic load_clr = 1'b1;
    logic [15:0] high_cnt;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [7:0] v;
    logic [7:0] w;
    logic p;
    logic [7:0] t_lim [7] = '{8'h03, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h03, 8'h03};
    logic [1:0] t_ps [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0};
    logic [7:0] t_ub [7] = '{8'h01, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h10};
    logic [1:0] t_lo [7] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h0, 2'h0};
    always #2 clk = ~clk;
    spwm_top uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_req(sleep_req),
        .waveform_pin_o(pin_o), .waveform_pin_oe(pin_oe));
    spwm_load load (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .line(line),
        .clr(load_clr), .high_cnt(high_cnt));
    // ----------------------------------------------------------
    // register port tasks
    // ----------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic close_out;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // one waveform setting, high time over four whole periods
    task automatic run_entry(input int i);
        int r;
        int per;
        int hi;
        r = (t_ps[i] == 2'h0) ? 1 : (t_ps[i] == 2'h1) ? 4 : 16;
        per = (int'(t_lim[i]) + 1) * 4 * r;
        hi = int'({t_ub[i], t_lo[i]}) * r;
        if (hi > per)
            hi = per;
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_LIMIT, t_lim[i]);
        wr(ADDR_DBUF, t_ub[i]);
        wr(ADDR_CTRL, {2'h0, t_lo[i], 4'hC});
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_TCON, {1'b0, 4'hF, 1'b1, t_ps[i]});
        repeat (2 * per + 8) @(posedge clk);
        load_clr <= 1'b1;
        @(posedge clk);
        load_clr <= 1'b0;
        repeat (4 * per) @(posedge clk);
        #1;
        `CHK(high_cnt, 16'(4 * hi))
    endtask : run_entry
    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        wr(3'h6, 8'h55);
        for (int a = 0; a < 8; a++)
        begin
            rd(3'(a), v);
            `CHK(v, 8'h00)
        end
        `CHK(pin_oe, 1'b0)
        wr(ADDR_CTRL, 8'hFF);
        rd(ADDR_CTRL, v);
        `CHK(v, 8'h3F)
        wr(ADDR_TCON, 8'hFF);
        rd(ADDR_TCON, v);
        `CHK(v, 8'h7F)
        for (int m = 0; m < 16; m++)
        begin
            wr(ADDR_CTRL, 8'(m));
            #1;
            `CHK(pin_oe, (m >= 12) ? 1'b1 : 1'b0)
        end
        for (int i = 0; i < 7; i++)
        begin
            run_entry(i);
        end
        wr(ADDR_CTRL, 8'h00);
        @(posedge clk);
        #1;
        `CHK(pin_o, 1'b0)
        run_entry(0);
        // timer held so no rollover can slip in
        wr(ADDR_TCON, 8'h00);
        wr(ADDR_DBUF, 8'h03);
        rd(ADDR_DACT, v);
        `CHK(v, 8'h01)
        wr(ADDR_DACT, 8'hAA);
        rd(ADDR_DACT, v);
        `CHK(v, 8'h01)
        wr(ADDR_TCON, 8'h04);
        repeat (20) @(posedge clk);
        rd(ADDR_DACT, v);
        `CHK(v, 8'h03)
        sleep_req <= 1'b1;
        rd(ADDR_COUNT, v);
        p = pin_o;
        repeat (21) @(posedge clk);
        rd(ADDR_COUNT, w);
        `CHK(w, v)
        `CHK(pin_o, p)
        sleep_req <= 1'b0;
        rd(ADDR_COUNT, v);
        repeat (2) @(posedge clk);
        rd(ADDR_COUNT, w);
        `CHK(w, (v + 8'h01) & 8'h03)
        wr(ADDR_CTRL, 8'h08);
        wr(ADDR_DACT, 8'h5A);
        wr(ADDR_DBUF, 8'h22);
        repeat (40) @(posedge clk);
        rd(ADDR_DACT, v);
        `CHK(v, 8'h5A)
        `CHK(pin_oe, 1'b0)
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        `CHK(pin_oe, 1'b0)
        rd(ADDR_LIMIT, v);
        `CHK(v, 8'h00)
        close_out();
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("MISMATCH %0t run out of time", $time);
        close_out();
    end
endmodule : spwm_top_test
